// file: dpctl_pkg.sv
// Constants shared by the dual-port RAM port controller
package dpctl_pkg;

   // ********************************
   // Timing
   // ********************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int T_ARB_NS = 20;      // Contention flag settle after match
   localparam int T_ACCESS_NS = 20;   // Read data valid after gate low
   localparam int T_WRITE_NS = 40;    // Write strobe low time
   localparam int SYNC_LAT = 4;       // Three flops plus agreement stage
   localparam logic [3:0] SETUP_CYC =
      4'((T_ARB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
   localparam logic [3:0] READ_CYC =
      4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
   localparam logic [3:0] WRITE_CYC =
      4'((T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ********************************
   // Register map
   // ********************************
   localparam logic [7:0] OFF_ADDR = 8'h00;
   localparam logic [7:0] OFF_WDATA = 8'h04;
   localparam logic [7:0] OFF_CMD = 8'h08;
   localparam logic [7:0] OFF_CFG = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_RDATA = 8'h14;
   localparam logic [2:0] IDX_ADDR = 3'h0;
   localparam logic [2:0] IDX_WDATA = 3'h1;
   localparam logic [2:0] IDX_CMD = 3'h2;
   localparam logic [2:0] IDX_CFG = 3'h3;
   localparam logic [2:0] IDX_STATUS = 3'h4;
   localparam logic [2:0] IDX_RDATA = 3'h5;
   localparam logic [2:0] IDX_NONE = 3'h7;
   localparam int CMD_GO = 0;
   localparam int CMD_WRITE = 1;
   localparam int CMD_SPACE = 2;
   localparam int CFG_ROLE = 0;       // 1 = device is arbiter
   localparam int CFG_ALLOW = 1;      // Slave role: 1 = writes allowed
   localparam int CFG_STALL = 2;      // Wait while contention flag low
   localparam logic [2:0] CFG_RESET = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********************************
   // Device side
   // ********************************
   localparam logic [15:0] MBOX_LEFT = 16'hFFFE;
   localparam logic [15:0] MBOX_RIGHT = 16'hFFFF;
   localparam int SYNC_W = 11;        // {irq, contention, data[8:0]}
   localparam logic [10:0] SYNC_RESET = 11'h600;

endpackage

// file: port_cmd_if.sv
// Command and status carrier between register file and pin sequencer
`timescale 1ns/10ps
interface port_cmd_if;
   logic go;
   logic write;
   logic space;
   logic stall_en;
   logic [15:0] addr;
   logic [8:0] wdata;
   logic busy;
   logic done;
   logic [8:0] rdata;
   logic contention_seen;
   logic init_done;

   modport ctrl (output go, write, space, stall_en, addr, wdata,
      input busy, done, rdata, contention_seen, init_done);
   modport seq (input go, write, space, stall_en, addr, wdata,
      output busy, done, rdata, contention_seen, init_done);
endinterface

// file: port_sequencer.sv
// Pin cycle sequencer for one port of the dual-port RAM
`timescale 1ns/10ps
module port_sequencer
#(
   parameter bit LEFT_PORT = 1'b1
)
(
   input wire logic i_clock,
   input wire logic i_resetn,
   port_cmd_if.seq cmd,
   input wire logic [8:0] i_data_f,
   input wire logic i_flag_n_f,
   output logic o_chip_sel_n,
   output logic o_chip_sel,
   output logic o_write_n,
   output logic o_output_gate_n,
   output logic o_flag_space_select_n,
   output logic [15:0] o_addr,
   output logic [8:0] o_data,
   output logic o_data_oe_n
);
   localparam logic [15:0] OWN_MBOX =
      LEFT_PORT ? dpctl_pkg::MBOX_LEFT : dpctl_pkg::MBOX_RIGHT;

   typedef enum {ST_IDLE, ST_SETUP, ST_WAIT_FREE, ST_STROBE,
      ST_RELEASE} seq_state_t;

   seq_state_t state_reg;
   logic [3:0] cnt_reg;
   logic init_pending_reg;
   logic write_reg;
   logic space_reg;
   logic stall_reg;
   logic done_reg;
   logic seen_reg;
   logic [8:0] rdata_reg;

   assign cmd.busy = (state_reg != ST_IDLE) || init_pending_reg;
   assign cmd.done = done_reg;
   assign cmd.rdata = rdata_reg;
   assign cmd.contention_seen = seen_reg;
   assign cmd.init_done = !init_pending_reg;

   // ****************************************
   // Access state machine
   // ****************************************
   // First access after reset reads our own mailbox, which clears
   // a stale interrupt left over from power-up
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         init_pending_reg <= 1'b1;
         write_reg <= 1'b0;
         space_reg <= 1'b0;
         stall_reg <= 1'b0;
         done_reg <= 1'b0;
         seen_reg <= 1'b0;
         rdata_reg <= 9'h000;
         o_chip_sel_n <= 1'b1;
         o_chip_sel <= 1'b0;
         o_write_n <= 1'b1;
         o_output_gate_n <= 1'b1;
         o_flag_space_select_n <= 1'b1;
         o_addr <= 16'h0000;
         o_data <= 9'h000;
         o_data_oe_n <= 1'b1;
      end
      else
      begin
         done_reg <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (init_pending_reg || cmd.go)
               begin
                  // Init read wins over a queued command
                  write_reg <= init_pending_reg ? 1'b0 : cmd.write;
                  space_reg <= init_pending_reg ? 1'b0 : cmd.space;
                  stall_reg <= init_pending_reg ? 1'b0 : cmd.stall_en;
                  o_addr <= init_pending_reg ? OWN_MBOX : cmd.addr;
                  o_data <= cmd.wdata;
                  o_data_oe_n <= init_pending_reg || !cmd.write;
                  // Flag space needs the array select held off
                  if (!init_pending_reg && cmd.space)
                  begin
                     o_flag_space_select_n <= 1'b0;
                  end
                  else
                  begin
                     o_chip_sel_n <= 1'b0;
                     o_chip_sel <= 1'b1;
                  end
                  seen_reg <= 1'b0;
                  cnt_reg <= dpctl_pkg::SETUP_CYC - 4'h1;
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               // Address and select settle so arbitration decides
               // before any strobe goes low
               if (cnt_reg == 4'h0)
                  state_reg <= ST_WAIT_FREE;
               else
                  cnt_reg <= cnt_reg - 4'h1;
            end
            ST_WAIT_FREE:
            begin
               if (!i_flag_n_f)
                  seen_reg <= 1'b1;
               // Optional hold-off; may wait forever if never freed
               if (!(stall_reg && !i_flag_n_f && !space_reg))
               begin
                  o_write_n <= !write_reg;
                  o_output_gate_n <= write_reg;
                  cnt_reg <= write_reg ? dpctl_pkg::WRITE_CYC - 4'h1 :
                     dpctl_pkg::READ_CYC - 4'h1;
                  state_reg <= ST_STROBE;
               end
            end
            ST_STROBE:
            begin
               if (!i_flag_n_f && !space_reg)
                  seen_reg <= 1'b1;
               if (cnt_reg == 4'h0)
               begin
                  o_write_n <= 1'b1;
                  o_output_gate_n <= 1'b1;
                  if (!write_reg)
                     rdata_reg <= i_data_f;
                  state_reg <= ST_RELEASE;
               end
               else
               begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_RELEASE:
            begin
               // Both selects rise, so the next flag read recaptures
               o_chip_sel_n <= 1'b1;
               o_chip_sel <= 1'b0;
               o_flag_space_select_n <= 1'b1;
               o_data_oe_n <= 1'b1;
               init_pending_reg <= 1'b0;
               done_reg <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   sequence seq_write_low;
      (!o_write_n) [*2];
   endsequence

   sequence seq_gate_mbox;
      !o_output_gate_n && !o_chip_sel_n && (o_addr == OWN_MBOX);
   endsequence

   flag_space_sel_a: assert property (
      !o_flag_space_select_n |-> o_chip_sel_n && !o_chip_sel)
      else $error("flag space access with array selected");

   stall_hold_a: assert property (
      (state_reg == ST_WAIT_FREE && stall_reg && !i_flag_n_f && !space_reg)
      |=> o_write_n && o_output_gate_n && state_reg == ST_WAIT_FREE)
      else $error("strobe issued while contention flag low");

   init_clear_a: assert property (
      $rose(i_resetn) |-> ##[1:20] seq_gate_mbox)
      else $error("own mailbox not read after reset");

   write_pulse_a: assert property (
      $fell(o_write_n) |-> seq_write_low ##1 o_write_n)
      else $error("write strobe not two cycles");

   no_bus_fight_a: assert property (
      !o_data_oe_n |-> o_output_gate_n)
      else $error("data driven while device output gate low");

   strobe_inside_a: assert property (
      (!o_write_n || !o_output_gate_n) |->
      (!$past(o_chip_sel_n) || !$past(o_flag_space_select_n)))
      else $error("strobe without prior select");
endmodule

// file: dpram_port_ctrl.sv
// AXI4-Lite controlled host for one port of a dual-port RAM
`timescale 1ns/10ps
module dpram_port_ctrl
#(
   parameter bit LEFT_PORT = 1'b1
)
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic o_chip_sel_n,
   output logic o_chip_sel,
   output logic o_write_n,
   output logic o_output_gate_n,
   output logic o_flag_space_select_n,
   output logic [15:0] o_addr,
   output logic [8:0] o_data,
   output logic o_data_oe_n,
   input wire logic [8:0] i_data,
   input wire logic i_contention_flag_n,
   output logic o_contention_flag_n,
   output logic o_contention_oe_n,
   output logic o_role_master,
   input wire logic i_mailbox_irq_n
);
   port_cmd_if cmd ();

   logic aw_ready_reg;
   logic w_ready_reg;
   logic b_valid_reg;
   logic [1:0] b_resp_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic ar_ready_reg;
   logic r_valid_reg;
   logic [1:0] r_resp_reg;
   logic [31:0] r_data_reg;
   logic [15:0] addr_reg;
   logic [8:0] wdata_reg;
   logic [2:1] cmd_reg;
   logic [2:0] cfg_reg;
   logic go_reg;
   logic [dpctl_pkg::SYNC_W-1:0] s1_reg;
   logic [dpctl_pkg::SYNC_W-1:0] s2_reg;
   logic [dpctl_pkg::SYNC_W-1:0] s3_reg;
   logic [dpctl_pkg::SYNC_W-1:0] filt_reg;
   logic commit;
   logic [2:0] w_idx;
   logic [31:0] merged;
   logic [31:0] read_word;
   logic [2:0] r_idx;

   // Byte address to register index; unmapped gives IDX_NONE
   function automatic logic [2:0] reg_index(input logic [7:0] a);
      if (a == dpctl_pkg::OFF_ADDR)
         return dpctl_pkg::IDX_ADDR;
      else if (a == dpctl_pkg::OFF_WDATA)
         return dpctl_pkg::IDX_WDATA;
      else if (a == dpctl_pkg::OFF_CMD)
         return dpctl_pkg::IDX_CMD;
      else if (a == dpctl_pkg::OFF_CFG)
         return dpctl_pkg::IDX_CFG;
      else if (a == dpctl_pkg::OFF_STATUS)
         return dpctl_pkg::IDX_STATUS;
      else if (a == dpctl_pkg::OFF_RDATA)
         return dpctl_pkg::IDX_RDATA;
      else
         return dpctl_pkg::IDX_NONE;
   endfunction

   // ****************************************
   // AXI4-Lite write channels
   // ****************************************
   assign commit = !aw_ready_reg && !w_ready_reg && !b_valid_reg;
   assign w_idx = reg_index(aw_addr_reg);

   // Address and data latched in either order; answer one cycle later
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         aw_ready_reg <= 1'b1;
         w_ready_reg <= 1'b1;
         b_valid_reg <= 1'b0;
         b_resp_reg <= dpctl_pkg::RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end
      else
      begin
         if (i_s_axi_awvalid && aw_ready_reg)
         begin
            aw_ready_reg <= 1'b0;
            aw_addr_reg <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && w_ready_reg)
         begin
            w_ready_reg <= 1'b0;
            w_data_reg <= i_s_axi_wdata;
            w_strb_reg <= i_s_axi_wstrb;
         end
         if (commit)
         begin
            b_valid_reg <= 1'b1;
            b_resp_reg <= (w_idx == dpctl_pkg::IDX_NONE) ?
               dpctl_pkg::RESP_SLVERR : dpctl_pkg::RESP_OKAY;
         end
         else if (b_valid_reg && i_s_axi_bready)
         begin
            b_valid_reg <= 1'b0;
            aw_ready_reg <= 1'b1;
            w_ready_reg <= 1'b1;
         end
      end
   end

   // Byte-lane merge of new data into a zero-extended old value
   always_comb
   begin
      merged = 32'h00000000;
      if (w_idx == dpctl_pkg::IDX_ADDR)
         merged = {16'h0000, addr_reg};
      else if (w_idx == dpctl_pkg::IDX_WDATA)
         merged = {23'h000000, wdata_reg};
      else if (w_idx == dpctl_pkg::IDX_CMD)
         merged = {29'h00000000, cmd_reg, 1'b0};
      else if (w_idx == dpctl_pkg::IDX_CFG)
         merged = {29'h00000000, cfg_reg};
      for (int b = 0; b < 4; b++)
      begin
         if (w_strb_reg[b])
            merged[b*8 +: 8] = w_data_reg[b*8 +: 8];
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         addr_reg <= 16'h0000;
         wdata_reg <= 9'h000;
         cmd_reg <= 2'h0;
         cfg_reg <= dpctl_pkg::CFG_RESET;
      end
      else if (commit)
      begin
         if (w_idx == dpctl_pkg::IDX_ADDR)
            addr_reg <= merged[15:0];
         else if (w_idx == dpctl_pkg::IDX_WDATA)
            wdata_reg <= merged[8:0];
         else if (w_idx == dpctl_pkg::IDX_CMD)
            cmd_reg <= merged[2:1];
         else if (w_idx == dpctl_pkg::IDX_CFG)
            cfg_reg <= merged[2:0];
      end
   end

   // Start pulse; a command written while busy is dropped
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
         go_reg <= 1'b0;
      else
         go_reg <= commit && w_idx == dpctl_pkg::IDX_CMD &&
            merged[dpctl_pkg::CMD_GO] && !cmd.busy;
   end

   // Pin drive straight from configuration flops
   assign o_role_master = cfg_reg[dpctl_pkg::CFG_ROLE];
   assign o_contention_oe_n = cfg_reg[dpctl_pkg::CFG_ROLE];
   assign o_contention_flag_n = cfg_reg[dpctl_pkg::CFG_ALLOW];

   assign cmd.go = go_reg;
   assign cmd.write = cmd_reg[dpctl_pkg::CMD_WRITE];
   assign cmd.space = cmd_reg[dpctl_pkg::CMD_SPACE];
   assign cmd.stall_en = cfg_reg[dpctl_pkg::CFG_STALL];
   assign cmd.addr = addr_reg;
   assign cmd.wdata = wdata_reg;

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   assign r_idx = reg_index(i_s_axi_araddr);

   always_comb
   begin
      read_word = 32'h00000000;
      if (r_idx == dpctl_pkg::IDX_ADDR)
         read_word = {16'h0000, addr_reg};
      else if (r_idx == dpctl_pkg::IDX_WDATA)
         read_word = {23'h000000, wdata_reg};
      else if (r_idx == dpctl_pkg::IDX_CMD)
         read_word = {29'h00000000, cmd_reg, 1'b0};
      else if (r_idx == dpctl_pkg::IDX_CFG)
         read_word = {29'h00000000, cfg_reg};
      else if (r_idx == dpctl_pkg::IDX_STATUS)
         read_word = {27'h0000000, filt_reg[9], cmd.init_done,
            !filt_reg[10], cmd.contention_seen, cmd.busy};
      else if (r_idx == dpctl_pkg::IDX_RDATA)
         read_word = {23'h000000, cmd.rdata};
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         ar_ready_reg <= 1'b1;
         r_valid_reg <= 1'b0;
         r_resp_reg <= dpctl_pkg::RESP_OKAY;
         r_data_reg <= 32'h00000000;
      end
      else if (i_s_axi_arvalid && ar_ready_reg)
      begin
         ar_ready_reg <= 1'b0;
         r_valid_reg <= 1'b1;
         r_data_reg <= read_word;
         r_resp_reg <= (r_idx == dpctl_pkg::IDX_NONE) ?
            dpctl_pkg::RESP_SLVERR : dpctl_pkg::RESP_OKAY;
      end
      else if (r_valid_reg && i_s_axi_rready)
      begin
         r_valid_reg <= 1'b0;
         ar_ready_reg <= 1'b1;
      end
   end

   assign o_s_axi_awready = aw_ready_reg;
   assign o_s_axi_wready = w_ready_reg;
   assign o_s_axi_bvalid = b_valid_reg;
   assign o_s_axi_bresp = b_resp_reg;
   assign o_s_axi_arready = ar_ready_reg;
   assign o_s_axi_rvalid = r_valid_reg;
   assign o_s_axi_rresp = r_resp_reg;
   assign o_s_axi_rdata = r_data_reg;

   // ****************************************
   // Pin input synchronisers
   // ****************************************
   // Per bit: a new level counts only once stages two and three agree
   generate
      for (genvar i = 0; i < dpctl_pkg::SYNC_W; i++)
      begin : g_sync
         always_ff @(posedge i_clock)
         begin
            if (!i_resetn)
            begin
               s1_reg[i] <= dpctl_pkg::SYNC_RESET[i];
               s2_reg[i] <= dpctl_pkg::SYNC_RESET[i];
               s3_reg[i] <= dpctl_pkg::SYNC_RESET[i];
               filt_reg[i] <= dpctl_pkg::SYNC_RESET[i];
            end
            else
            begin
               s1_reg[i] <= (i == 10) ? i_mailbox_irq_n :
                  (i == 9) ? i_contention_flag_n : i_data[i % 9];
               s2_reg[i] <= s1_reg[i];
               s3_reg[i] <= s2_reg[i];
               if (s2_reg[i] == s3_reg[i])
                  filt_reg[i] <= s3_reg[i];
            end
         end
      end
   endgenerate

   port_sequencer #(.LEFT_PORT(LEFT_PORT)) u_seq (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .cmd(cmd),
      .i_data_f(filt_reg[8:0]),
      .i_flag_n_f(filt_reg[9]),
      .o_chip_sel_n(o_chip_sel_n),
      .o_chip_sel(o_chip_sel),
      .o_write_n(o_write_n),
      .o_output_gate_n(o_output_gate_n),
      .o_flag_space_select_n(o_flag_space_select_n),
      .o_addr(o_addr),
      .o_data(o_data),
      .o_data_oe_n(o_data_oe_n)
   );

   // ****************************************
   // Checks
   // ****************************************
   cfg_pin_drive_a: assert property (
      @(posedge i_clock) disable iff (!i_resetn)
      (commit && w_idx == dpctl_pkg::IDX_CFG && w_strb_reg[0]) |=>
      (o_contention_oe_n == $past(w_data_reg[0])) &&
      (o_contention_flag_n == $past(w_data_reg[1])))
      else $error("contention pin drive does not follow config");

   access_done_a: assert property (
      @(posedge i_clock) disable iff (!i_resetn)
      cmd.done |-> !cmd.busy)
      else $error("done flagged while sequencer busy");
endmodule

// file: dp_dev_model.sv
// Behavioural dual-port RAM as seen from the controller's port
`timescale 1ns/10ps
module dp_dev_model
(
   input wire logic i_cs_n,
   input wire logic i_cs,
   input wire logic i_we_n,
   input wire logic i_oe_n,
   input wire logic i_flag_sel_n,
   input wire logic [15:0] i_a,
   input wire logic [8:0] i_d,
   input wire logic i_master,
   input wire logic i_pin_n,
   output logic [8:0] o_d,
   output logic o_cont_n,
   output logic o_irq_n
);
   logic [8:0] mem [int];
   logic [1:0][7:0] h;
   logic [1:0][7:0] q;
   logic [8:0] sl;
   logic [8:0] v;
   logic rirq_n;
   logic ron;
   logic [15:0] ra;
   wire sel = !i_cs_n && i_cs;
   wire blk = i_master ? !o_cont_n : !i_pin_n;
   // Far port is always first, so only this side is ever flagged
   assign o_cont_n = !(i_master && sel && ron && ra == i_a);
   // Power-up state; own mailbox flag starts stale on purpose
   initial
   begin
      h = '0;
      q = '0;
      sl = 9'h000;
      o_irq_n = 1'b0;
      rirq_n = 1'b1;
      ron = 1'b0;
      ra = 16'h0000;
   end
   // Token passing for one flag, either side
   task sw(input int s, input int i, input bit b);
      if (!b && !h[0][i] && !h[1][i])
         h[s][i] = 1'b1;
      else if (!b && !h[s][i])
         q[s][i] = 1'b1;
      else if (b && h[s][i])
      begin
         h[s][i] = 1'b0;
         h[1-s][i] = q[1-s][i];
         q[1-s][i] = 1'b0;
      end
   endtask
   // Far port writes a word
   task ow(input logic [15:0] a, input logic [8:0] d);
      mem[a] = d;
      if (a == 16'hFFFE)
         o_irq_n = 1'b0;
   endtask
   // Write lands as the strobe rises
   always @(posedge i_we_n)
   begin
      if (sel && !blk)
      begin
         mem[i_a] = i_d;
         if (i_a == 16'hFFFF)
            rirq_n = 1'b0;
      end
      if (!i_flag_sel_n && i_cs_n)
         sw(0, i_a[2:0], i_d[0]);
   end
   // Gate edge clears own mailbox and freezes the flag read
   always @(negedge i_oe_n)
   begin
      if (sel && i_a == 16'hFFFE)
         o_irq_n = 1'b1;
      sl = {9{!h[0][i_a[2:0]]}};
   end
   // Released data lines show the inverse, never a stale match
   always @*
   begin
      v = !i_flag_sel_n ? sl : (mem.exists(i_a) ? mem[i_a] : 9'h000);
      o_d = (!i_oe_n && (sel || !i_flag_sel_n)) ? v : ~v;
   end
endmodule

// file: testbench.sv
// Self-checking bench for the dual-port RAM port controller
`timescale 1ns/10ps
module testbench;
   logic i_clock, i_resetn, i_s_axi_awvalid, i_s_axi_wvalid;
   logic i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
   logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata, r;
   logic [3:0] i_s_axi_wstrb;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rs;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
   logic o_s_axi_arready, o_s_axi_rvalid, o_chip_sel_n, o_chip_sel;
   logic o_write_n, o_output_gate_n, o_flag_space_select_n;
   logic o_data_oe_n, o_contention_flag_n, o_contention_oe_n;
   logic o_role_master, i_mailbox_irq_n, dev_n;
   logic [15:0] o_addr, ad, a0;
   logic [8:0] o_data, i_data, wd;
   logic [8:0] em [int];
   int fails, cmp_count, seed, i, n;
   wire i_contention_flag_n = o_contention_oe_n ? dev_n : o_contention_flag_n;
   dpram_port_ctrl uut (.*);
   dp_dev_model dev (.i_cs_n(o_chip_sel_n), .i_cs(o_chip_sel),
      .i_we_n(o_write_n), .i_oe_n(o_output_gate_n),
      .i_flag_sel_n(o_flag_space_select_n), .i_a(o_addr), .i_d(o_data),
      .i_master(o_role_master), .i_pin_n(i_contention_flag_n),
      .o_d(i_data), .o_cont_n(dev_n), .o_irq_n(i_mailbox_irq_n));
   // Free-running clock
   initial
   begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   task give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   // Bounded waits end the run instead of hanging
   task tmo(input int k);
      if (k > 300)
      begin
         fails++;
         give_verdict;
      end
   endtask
   // AXI write: both channels offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, b;
      b = 1'b0;
      @(posedge i_clock);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      for (int k = 0; !b; k++)
      begin
         tmo(k);
         @(negedge i_clock);
         ta = i_s_axi_awvalid && o_s_axi_awready;
         tw = i_s_axi_wvalid && o_s_axi_wready;
         b = o_s_axi_bvalid;
         rs = o_s_axi_bresp;
         @(posedge i_clock);
         if (ta) i_s_axi_awvalid <= 1'b0;
         if (tw) i_s_axi_wvalid <= 1'b0;
      end
      i_s_axi_bready <= 1'b0;
   endtask
   // AXI read; data and response sampled on the falling edge before the handshake edge
   task rd(input logic [7:0] a);
      logic ta, b;
      b = 1'b0;
      @(posedge i_clock);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      for (int k = 0; !b; k++)
      begin
         tmo(k);
         @(negedge i_clock);
         ta = i_s_axi_arvalid && o_s_axi_arready;
         b = o_s_axi_rvalid;
         r = o_s_axi_rdata;
         rs = o_s_axi_rresp;
         @(posedge i_clock);
         if (ta) i_s_axi_arvalid <= 1'b0;
      end
      i_s_axi_rready <= 1'b0;
   endtask
   // One device access: c = go | write<<1 | space<<2
   task acc(input logic [2:0] c, input logic [15:0] a, input logic [8:0] d);
      wr(8'h00, {16'h0000, a});
      wr(8'h04, {23'h000000, d});
      wr(8'h08, {29'h00000000, c});
      r = 32'h00000001;
      for (int k = 0; r[0] !== 1'b0; k++)
      begin
         tmo(k);
         rd(8'h10);
      end
      rd(8'h14);
   endtask
   // Main sequence
   initial
   begin
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 3'h0;
      {i_s_axi_arvalid, i_s_axi_rready, i_resetn} = 3'h0;
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
      i_s_axi_wstrb = 4'hF;
      seed = 1148;
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      r = 32'h00000000;
      for (n = 0; r[3] !== 1'b1; n++)
      begin
         tmo(n);
         rd(8'h10);
      end
      chk(r[2], 1'b0);
      rd(8'h0C);
      chk(r[2:0], 3'h3);
      rd(8'h3C);
      chk(rs, 2'h2);
      wr(8'h3C, 32'h00000000);
      chk(rs, 2'h2);
      $display("test reset done");
      repeat (4)
      begin
         ad = 16'($random(seed)) & 16'h7FFF;
         wd = 9'($random(seed));
         acc(3'h3, ad, wd);
         em[ad] = wd;
         acc(3'h1, ad, 9'h000);
         chk(r[8:0], em[ad]);
      end
      a0 = ad;
      $display("test array done");
      dev.ow(16'hFFFE, 9'h1A5);
      repeat (8) @(posedge i_clock);
      rd(8'h10);
      chk(r[2], 1'b1);
      acc(3'h1, 16'hFFFE, 9'h000);
      chk(r[8:0], 9'h1A5);
      rd(8'h10);
      chk(r[2], 1'b0);
      acc(3'h3, 16'hFFFF, 9'h0C3);
      chk(dev.rirq_n, 1'b0);
      $display("test mailbox done");
      for (i = 0; i < 8; i++)
      begin
         ad = 16'($random(seed)) & 16'hFFF8 | 16'(i);
         acc(3'h7, ad, 9'h000);
         acc(3'h5, ad, 9'h000);
         chk(r[8:0], 9'h000);
         dev.sw(1, i, 1'b0);
         acc(3'h7, ad, 9'h001);
         acc(3'h5, ad, 9'h000);
         chk(r[8:0], 9'h1FF);
         acc(3'h7, ad, 9'h000);
         dev.sw(1, i, 1'b1);
         acc(3'h5, ad, 9'h000);
         chk(r[8:0], 9'h000);
         acc(3'h7, ad, 9'h001);
         acc(3'h5, ad, 9'h000);
         chk(r[8:0], 9'h1FF);
      end
      acc(3'h1, a0, 9'h000);
      chk(r[8:0], em[a0]);
      $display("test flags done");
      dev.ra = a0;
      dev.ron = 1'b1;
      acc(3'h3, a0, ~em[a0]);
      rd(8'h10);
      chk(r[1], 1'b1);
      dev.ron = 1'b0;
      acc(3'h1, a0, 9'h000);
      chk(r[8:0], em[a0]);
      rd(8'h10);
      chk(r[1], 1'b0);
      wr(8'h0C, 32'h00000000);
      chk(o_role_master, 1'b0);
      chk({o_contention_oe_n, o_contention_flag_n}, 2'h0);
      acc(3'h3, a0, ~em[a0]);
      acc(3'h1, a0, 9'h000);
      chk(r[8:0], em[a0]);
      wr(8'h0C, 32'h00000002);
      acc(3'h3, a0, 9'h055);
      acc(3'h1, a0, 9'h000);
      chk(r[8:0], 9'h055);
      // Stall enabled: access must wait while the far side flags us
      wr(8'h0C, 32'h00000005);
      dev.ron = 1'b1;
      fork
         acc(3'h3, a0, 9'h0AA);
         begin
            repeat (60) @(negedge i_clock);
            chk(o_chip_sel_n, 1'b0);
            dev.ron = 1'b0;
         end
      join
      acc(3'h1, a0, 9'h000);
      chk(r[8:0], 9'h0AA);
      $display("test contention done");
      give_verdict;
   end
endmodule
